// *** rtl/chg_dir_map.svh ***
// Constants for the channel change directive decoder
`ifndef CHG_DIR_MAP_SVH
`define CHG_DIR_MAP_SVH
`define ELEM_UP_CHAN 8'h01
`define ELEM_DOWN_PARAM 8'h02
`define ELEM_INIT_TECH 8'h03
`define ELEM_DESC_SUBST 8'h04
`define ELEM_SEC_SUBST 8'h05
`define ELEM_FLOW_SUBST 8'h07
`define SUB_FLOW_ID 8'h01
`define SUB_SVC_ID 8'h02
`define SUB_GRANT_REF 8'h05
`define SUB_DOWN_FREQ 8'h01
`define INIT_FULL 8'h00
`define INIT_DIRECT 8'h04
`define FRAG_LEN 8'hfe
`define DESC_DEPTH 1024
`define DESC_AW 10
`endif

// *** rtl/chg_dir_pkg.sv ***
// Types for the channel change directive decoder
package chg_dir_pkg;
	typedef enum logic [2:0] {
		LVL_FULL,
		LVL_INITIAL,
		LVL_STATION,
		LVL_EITHER,
		LVL_DIRECT
	} init_level_t;
	typedef enum {
		ST_TYPE,
		ST_LEN,
		ST_VAL,
		ST_SUBTYPE,
		ST_SUBLEN,
		ST_SUBVAL
	} parse_state_t;
endpackage

// *** rtl/level_decode.sv ***
// Maps the initialization technique code onto a re-initialization level
`timescale 1ns/1ns
module level_decode (
	input wire logic present,
	input wire logic [7:0] code,
	output chg_dir_pkg::init_level_t level
);
	import chg_dir_pkg::*;
	// Absent element or reserved code means a full MAC re-initialization
	always_comb begin
		if (!present) begin
			level = LVL_FULL; // R8
		end else begin
			case (code)
				8'h00: level = LVL_FULL;
				8'h01: level = LVL_INITIAL;
				8'h02: level = LVL_STATION;
				8'h03: level = LVL_EITHER;
				8'h04: level = LVL_DIRECT;
				default: level = LVL_FULL; // R25
			endcase
		end
	end
endmodule // level_decode

// *** rtl/channel_change_directive_decoder.sv ***
// Channel change request element decoder for the modem station
// Functional notes
// R1 - New channels are chosen from channel and frequency elements before the level acts.
// R2 - Code 0 ranges on the initialization handle; 1 to 4 keep the primary handle (code ranges on svc_new_r when a service substitution is given).
// R3 - Code 0 runs full init and ignores all but channel and downstream elements.
// R4 - Code 1 does initial maintenance first, allowing several ranging intervals.
// R5 - Code 2 does station maintenance first, allowing the maintenance timeout.
// R6 - Code 3 lets the station choose initial or station maintenance region.
// R7 - Code 4 resumes normal operation right after sync, no ranging.
// R8 - Missing technique element means full MAC re-initialization.
// R9 - Substituted descriptor is cached and applied only after sync.
// R10 - Controller splits long descriptors into 254-byte fragments except the last.
// R11 - Descriptor fragments are concatenated in arrival order without gaps.
// R12 - Controller gives the substitute the broadcast change count.
// R13 - Controller gives the new upstream channel a different identifier.
// R14 - Security handle substitution: current then new, low 14 of 16 bits.
// R15 - Privacy keys bound to the association stay unchanged.
// R16 - Without security substitution the assignment is kept.
// R17 - One flow element per changed flow; other flows stay unchanged.
// R18 - Quality-of-service parameters never change; only handles are remapped.
// R19 - Controller always sends the flow handle sub-element, length 8.
// R20 - Service handle substitution: current then new, low 14 bits, moves flow.
// R21 - Without service handle substitution the assignments are kept.
// R22 - Grant time reference replaced by 4-byte 7.5 value, else kept.
// R23 - Technique element is type 3, one byte, codes 0 to 4.
// R24 - Without re-init every unsubstituted configuration value is kept.
// R25 - Reserved technique codes 5 to 255 mean full re-initialization.
`timescale 1ns/1ns
`include "chg_dir_map.svh"
module channel_change_directive_decoder (
	input wire logic clk,
	input wire logic rst_b,
	// Request byte stream, elements only, from the message receiver
	input wire logic req_start,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic req_end,
	// Station status
	input wire logic synced_new_chan,
	input wire logic [13:0] primary_handle_in,
	input wire logic [13:0] init_handle_in,
	input wire logic [13:0] sec_handle_in,
	input wire logic [31:0] grant_ref_in,
	input wire logic [`DESC_AW-1:0] desc_rd_addr,
	// Decisions
	output chg_dir_pkg::init_level_t init_level,
	output logic directive_valid,
	output logic [7:0] new_up_chan,
	output logic up_chan_change,
	output logic [31:0] new_down_freq,
	output logic down_freq_change,
	output logic [13:0] ranging_handle,
	output logic ranging_initial_ok,
	output logic ranging_station_ok,
	output logic ranging_none,
	output logic desc_apply,
	output logic [`DESC_AW:0] desc_len,
	output logic [7:0] desc_rd_data,
	output logic [13:0] sec_handle,
	output logic flow_remap_valid,
	output logic [31:0] flow_old,
	output logic [31:0] flow_new,
	output logic [13:0] svc_old,
	output logic [13:0] svc_new,
	output logic svc_remap,
	output logic [31:0] grant_ref,
	output logic keys_kept
);
	import chg_dir_pkg::*;

	// ----------------------------------------------------------------
	// Element walker
	// ----------------------------------------------------------------
	parse_state_t st_r, st_nxt;
	logic [7:0] etype_r, elen_r, ecnt_r;
	logic [7:0] stype_r, slen_r, scnt_r;
	logic [63:0] shift_r;
	logic [7:0] desc_mem [0:`DESC_DEPTH-1];
	logic [`DESC_AW:0] wr_ptr_r;
	logic tech_seen_r;
	logic [7:0] tech_code_r;
	logic sec_seen_r;
	logic [13:0] sec_new_r;
	logic grant_seen_r;
	logic [31:0] grant_new_r;
	logic up_seen_r;
	logic [7:0] up_chan_r;
	logic freq_seen_r;
	logic [31:0] freq_r;
	logic desc_seen_r;
	logic svc_seen_r;
	logic [13:0] svc_old_r, svc_new_r;
	logic done_r, decided_r;
	init_level_t level_w;

	wire in_sub = (etype_r == `ELEM_FLOW_SUBST) || (etype_r == `ELEM_DOWN_PARAM);
	wire elem_last = byte_valid && (ecnt_r + 8'h01 == elen_r);
	wire sub_last = byte_valid && (scnt_r + 8'h01 == slen_r);
	wire [63:0] shift_nxt = {shift_r[55:0], byte_data};

	always_comb begin
		st_nxt = st_r;
		if (byte_valid) begin
			case (st_r)
				ST_TYPE: st_nxt = ST_LEN;
				ST_LEN: st_nxt = (byte_data == 8'h00) ? ST_TYPE : (in_sub ? ST_SUBTYPE : ST_VAL);
				ST_VAL: st_nxt = elem_last ? ST_TYPE : ST_VAL;
				ST_SUBTYPE: st_nxt = elem_last ? ST_TYPE : ST_SUBLEN;
				ST_SUBLEN: st_nxt = elem_last ? ST_TYPE :
					((byte_data == 8'h00) ? ST_SUBTYPE : ST_SUBVAL);
				ST_SUBVAL: begin
					if (elem_last) begin
						st_nxt = ST_TYPE;
					end else if (sub_last) begin
						st_nxt = ST_SUBTYPE;
					end else begin
						st_nxt = ST_SUBVAL;
					end
				end
				default: st_nxt = ST_TYPE;
			endcase
		end
		if (req_start) begin
			st_nxt = ST_TYPE;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= ST_TYPE;
			etype_r <= 8'h00;
			elen_r <= 8'h00;
			ecnt_r <= 8'h00;
			stype_r <= 8'h00;
			slen_r <= 8'h00;
			scnt_r <= 8'h00;
			shift_r <= 64'h0;
		end else begin
			st_r <= st_nxt;
			if (byte_valid) begin
				shift_r <= shift_nxt;
				if (st_r == ST_TYPE) begin
					etype_r <= byte_data;
				end
				if (st_r == ST_LEN) begin
					elen_r <= byte_data;
					ecnt_r <= 8'h00;
				end else if (st_r != ST_TYPE) begin
					ecnt_r <= ecnt_r + 8'h01;
				end
				if (st_r == ST_SUBTYPE) begin
					stype_r <= byte_data;
				end
				if (st_r == ST_SUBLEN) begin
					slen_r <= byte_data;
					scnt_r <= 8'h00;
				end else if (st_r == ST_SUBVAL) begin
					scnt_r <= scnt_r + 8'h01;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Captured elements
	// ----------------------------------------------------------------
	wire top_done = byte_valid && st_r == ST_VAL && elem_last;
	wire sub_done = byte_valid && st_r == ST_SUBVAL && sub_last;
	wire desc_wr = byte_valid && st_r == ST_VAL && etype_r == `ELEM_DESC_SUBST &&
		wr_ptr_r < `DESC_DEPTH;

	always_ff @(posedge clk) begin
		if (desc_wr) begin
			desc_mem[wr_ptr_r[`DESC_AW-1:0]] <= byte_data; // R11
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tech_seen_r <= 1'b0;
			tech_code_r <= 8'h00;
			up_seen_r <= 1'b0;
			up_chan_r <= 8'h00;
			freq_seen_r <= 1'b0;
			freq_r <= 32'h0;
			sec_seen_r <= 1'b0;
			sec_new_r <= 14'h0;
			grant_seen_r <= 1'b0;
			grant_new_r <= 32'h0;
			desc_seen_r <= 1'b0;
			wr_ptr_r <= '0;
			svc_seen_r <= 1'b0;
			svc_old_r <= 14'h0;
			svc_new_r <= 14'h0;
		end else if (req_start) begin
			tech_seen_r <= 1'b0;
			up_seen_r <= 1'b0;
			freq_seen_r <= 1'b0;
			sec_seen_r <= 1'b0;
			grant_seen_r <= 1'b0;
			desc_seen_r <= 1'b0;
			wr_ptr_r <= '0;
			svc_seen_r <= 1'b0;
		end else begin
			if (desc_wr) begin
				wr_ptr_r <= wr_ptr_r + 1'b1; // R11
				desc_seen_r <= 1'b1; // R9
			end
			if (top_done && etype_r == `ELEM_INIT_TECH) begin
				tech_seen_r <= 1'b1; // R23
				tech_code_r <= byte_data;
			end
			if (top_done && etype_r == `ELEM_UP_CHAN) begin
				up_seen_r <= 1'b1; // R1
				up_chan_r <= byte_data;
			end
			if (top_done && etype_r == `ELEM_SEC_SUBST) begin
				sec_seen_r <= 1'b1; // R14
				sec_new_r <= shift_nxt[13:0];
			end
			if (sub_done && etype_r == `ELEM_DOWN_PARAM && stype_r == `SUB_DOWN_FREQ) begin
				freq_seen_r <= 1'b1; // R1
				freq_r <= shift_nxt[31:0];
			end
			if (sub_done && etype_r == `ELEM_FLOW_SUBST && stype_r == `SUB_SVC_ID) begin
				svc_seen_r <= 1'b1; // R20
				svc_old_r <= shift_nxt[29:16];
				svc_new_r <= shift_nxt[13:0];
			end
			if (sub_done && etype_r == `ELEM_FLOW_SUBST && stype_r == `SUB_GRANT_REF) begin
				grant_seen_r <= 1'b1; // R22
				grant_new_r <= shift_nxt[31:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Directive outputs
	// ----------------------------------------------------------------
	level_decode u_level (
		.present(tech_seen_r),
		.code(tech_code_r),
		.level(level_w)
	);

	wire full_w = (level_w == LVL_FULL);
	// Substitutions only take effect when the MAC is not re-initialized
	wire keep_w = !full_w; // R3

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done_r <= 1'b0;
			directive_valid <= 1'b0;
			init_level <= LVL_FULL;
			new_up_chan <= 8'h00;
			up_chan_change <= 1'b0;
			new_down_freq <= 32'h0;
			down_freq_change <= 1'b0;
			ranging_handle <= 14'h0;
			ranging_initial_ok <= 1'b0;
			ranging_station_ok <= 1'b0;
			ranging_none <= 1'b0;
			sec_handle <= 14'h0;
			svc_old <= 14'h0;
			svc_new <= 14'h0;
			svc_remap <= 1'b0;
			grant_ref <= 32'h0;
			keys_kept <= 1'b0;
		end else begin
			done_r <= req_end;
			directive_valid <= done_r;
			if (done_r) begin
				// Channel selection is latched together with the level
				new_up_chan <= up_chan_r; // R1
				up_chan_change <= up_seen_r;
				new_down_freq <= freq_r;
				down_freq_change <= freq_seen_r;
				init_level <= level_w;
				ranging_handle <= full_w ? init_handle_in : // R2
					((keep_w && svc_seen_r) ? svc_new_r : primary_handle_in);
				ranging_initial_ok <= level_w == LVL_INITIAL || level_w == LVL_EITHER; // R4 R6
				ranging_station_ok <= level_w == LVL_STATION || level_w == LVL_EITHER; // R5 R6
				ranging_none <= level_w == LVL_DIRECT; // R7
				sec_handle <= (keep_w && sec_seen_r) ? sec_new_r : sec_handle_in; // R14 R16
				keys_kept <= keep_w; // R15
				svc_old <= svc_old_r;
				svc_new <= svc_new_r;
				svc_remap <= keep_w && svc_seen_r; // R20 R21
				grant_ref <= (keep_w && grant_seen_r) ? grant_new_r : grant_ref_in; // R22 R24
			end
		end
	end

	// ----------------------------------------------------------------
	// Flow handle remap, one pulse per flow handle sub-element received after a code 1 to 4 technique element, none otherwise
	// ----------------------------------------------------------------
	wire flow_id_done = sub_done && etype_r == `ELEM_FLOW_SUBST && stype_r == `SUB_FLOW_ID;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flow_remap_valid <= 1'b0;
			flow_old <= 32'h0;
			flow_new <= 32'h0;
		end else begin
			// Only handles are emitted; no QoS field is ever passed on
			flow_remap_valid <= flow_id_done && keep_w; // R17 R18
			if (flow_id_done) begin
				flow_old <= shift_nxt[63:32];
				flow_new <= shift_nxt[31:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Cached descriptor, released after sync on the new channel
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			desc_apply <= 1'b0;
			decided_r <= 1'b0;
			desc_len <= '0;
			desc_rd_data <= 8'h00;
		end else begin
			desc_rd_data <= desc_mem[desc_rd_addr];
			if (req_start) begin
				desc_apply <= 1'b0;
				decided_r <= 1'b0;
			end else begin
				// Sync may come long after the decision, so the decision is remembered
				decided_r <= decided_r || directive_valid;
				desc_apply <= synced_new_chan && desc_seen_r && keep_w && // R9
					(decided_r || directive_valid);
			end
			desc_len <= wr_ptr_r;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_level_full_handle: assert property (@(posedge clk) disable iff (!rst_b) // R2
		done_r && full_w |=> ranging_handle == $past(init_handle_in))
		else $error("Full re-init must range on initialization handle");
	chk_direct_no_ranging: assert property (@(posedge clk) disable iff (!rst_b) // R7
		directive_valid && init_level == LVL_DIRECT |-> ranging_none && !ranging_initial_ok)
		else $error("Direct use must not range");
	chk_desc_after_sync: assert property (@(posedge clk) disable iff (!rst_b) // R9
		desc_apply |-> $past(synced_new_chan))
		else $error("Descriptor applied before sync");
	chk_sec_keep: assert property (@(posedge clk) disable iff (!rst_b) // R16
		done_r && !sec_seen_r |=> sec_handle == $past(sec_handle_in))
		else $error("Security handle changed without substitution");
	chk_grant_keep: assert property (@(posedge clk) disable iff (!rst_b) // R22
		done_r && !grant_seen_r |=> grant_ref == $past(grant_ref_in))
		else $error("Grant reference changed without substitution");
	chk_full_no_remap: assert property (@(posedge clk) disable iff (!rst_b) // R3
		directive_valid && init_level == LVL_FULL |-> !svc_remap && !keys_kept)
		else $error("Full re-init applied a substitution");
	chk_either_both: assert property (@(posedge clk) disable iff (!rst_b) // R6
		directive_valid && init_level == LVL_EITHER |-> ranging_initial_ok && ranging_station_ok)
		else $error("Either level must allow both regions");
	chk_desc_append: assert property (@(posedge clk) disable iff (!rst_b) // R11
		desc_wr && !req_start |=> wr_ptr_r == $past(wr_ptr_r) + 1'b1)
		else $error("Descriptor bytes not appended");
	chk_valid_follows: assert property (@(posedge clk) disable iff (!rst_b) // R8
		req_end ##1 1'b1 |=> directive_valid)
		else $error("Directive did not follow request end");
endmodule // channel_change_directive_decoder

// *** testbench/headend_model.sv ***
// Headend controller model that frames channel change requests
`timescale 1ns/1ns
module headend_model (
	input wire logic clk,
	output logic req_start,
	output logic byte_valid,
	output logic [7:0] byte_data,
	output logic req_end
);
	logic [7:0] q[$];
	initial begin
		req_start = 1'b0;
		byte_valid = 1'b0;
		byte_data = 8'h00;
		req_end = 1'b0;
	end
	task put(input logic [7:0] b);
		q.push_back(b);
	endtask
	// Long descriptors leave as full fragments and a short tail
	task put_desc(input int n);
		int f;
		for (int k = 0; k < n; k++) begin
			if (k % 254 == 0) begin
				f = (n - k > 254) ? 254 : n - k;
				put(8'h04);
				put(f[7:0]);
			end
			put(k[7:0] ^ 8'h5a);
		end
	endtask
	task send();
		@(posedge clk) req_start <= 1'b1;
		@(posedge clk) req_start <= 1'b0;
		@(posedge clk);
		foreach (q[i]) begin
			@(posedge clk);
			byte_valid <= 1'b1;
			byte_data <= q[i];
		end
		@(posedge clk);
		byte_valid <= 1'b0;
		// Released bus shows the inverse so a stale byte cannot pass
		byte_data <= ~byte_data;
		@(posedge clk) req_end <= 1'b1;
		@(posedge clk) req_end <= 1'b0;
		q.delete();
	endtask
endmodule // headend_model

// *** testbench/channel_change_directive_decoder_bench.sv ***
// Randomised bench for the channel change directive decoder
`timescale 1ns/1ns
`include "chg_dir_map.svh"
module channel_change_directive_decoder_bench;
	import chg_dir_pkg::*;
	logic clk, rst_b, req_start, byte_valid, req_end, synced_new_chan;
	logic [7:0] byte_data, new_up_chan, desc_rd_data, ch;
	logic [13:0] primary_handle_in, init_handle_in, sec_handle_in;
	logic [13:0] ranging_handle, sec_handle, svc_old, svc_new;
	logic [31:0] grant_ref_in, new_down_freq, flow_old, flow_new, grant_ref;
	logic [31:0] fo, fn, eo, en, frq, gr;
	logic [`DESC_AW-1:0] desc_rd_addr;
	logic [`DESC_AW:0] desc_len;
	logic [15:0] so, sn, vo, vn;
	init_level_t init_level;
	logic directive_valid, up_chan_change, down_freq_change, ranging_initial_ok;
	logic ranging_station_ok, ranging_none, desc_apply, flow_remap_valid;
	logic svc_remap, keys_kept;
	int fails, tests_run, cyc, fcnt;
	int ad[5] = '{0, 1, 253, 254, 299};
	headend_model headend_model_i (.clk, .req_start, .byte_valid, .byte_data, .req_end);
	channel_change_directive_decoder channel_change_directive_decoder_i (.clk, .rst_b,
		.req_start, .byte_valid, .byte_data, .req_end, .synced_new_chan,
		.primary_handle_in, .init_handle_in, .sec_handle_in, .grant_ref_in,
		.desc_rd_addr, .init_level, .directive_valid, .new_up_chan, .up_chan_change,
		.new_down_freq, .down_freq_change, .ranging_handle, .ranging_initial_ok,
		.ranging_station_ok, .ranging_none, .desc_apply, .desc_len, .desc_rd_data,
		.sec_handle, .flow_remap_valid, .flow_old, .flow_new, .svc_old, .svc_new,
		.svc_remap, .grant_ref, .keys_kept);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Ceiling is more than ten times the longest expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			complete_run();
		end
	end
	always @(negedge clk) begin
		if (flow_remap_valid === 1'b1) begin
			fo = flow_old;
			fn = flow_new;
			fcnt++;
		end
	end
	function automatic init_level_t exp_level(input int c);
		if (c < 1 || c > 4) return LVL_FULL;
		return init_level_t'(c);
	endfunction
	function automatic logic [7:0] exp_desc(input int k);
		return k[7:0] ^ 8'h5a;
	endfunction
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task complete_run();
		$display("Counts: %0d checks, %0d mismatches", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task pb(input logic [7:0] b);
		headend_model_i.put(b);
	endtask
	task p16(input logic [15:0] v);
		pb(v[15:8]);
		pb(v[7:0]);
	endtask
	task p32(input logic [31:0] v);
		p16(v[31:16]);
		p16(v[15:0]);
	endtask
	task rnd_in();
		@(posedge clk);
		primary_handle_in <= 14'($urandom);
		init_handle_in <= 14'($urandom);
		sec_handle_in <= 14'($urandom);
		grant_ref_in <= $urandom;
	endtask
	task decide();
		int n;
		n = 0;
		headend_model_i.send();
		do @(negedge clk); while (directive_valid !== 1'b1 && ++n < 20);
		chk("dir_valid", 1, directive_valid);
	endtask
	task subst(input logic [7:0] code);
		int k;
		logic on;
		rnd_in();
		on = (code != 8'h00);
		ch = 8'($urandom);
		if (ch == new_up_chan) ch = ~ch;
		{frq, eo, en, gr} = {$urandom, $urandom, $urandom, $urandom};
		{so, sn, vo, vn} = {$urandom, $urandom};
		pb(8'h03); pb(8'h01); pb(code);
		pb(8'h01); pb(8'h01); pb(ch);
		pb(8'h02); pb(8'h06); pb(8'h01); pb(8'h04); p32(frq);
		pb(8'h05); pb(8'h04); p16(so); p16(sn);
		pb(8'h07); pb(8'h16); pb(8'h01); pb(8'h08); p32(eo); p32(en);
		pb(8'h02); pb(8'h04); p16(vo); p16(vn);
		pb(8'h05); pb(8'h04); p32(gr);
		k = fcnt;
		decide();
		chk("up_chan", ch, new_up_chan);
		chk("up_chg", 1, up_chan_change);
		chk("down_freq", frq, new_down_freq);
		chk("down_chg", 1, down_freq_change);
		chk("sec", on ? sn[13:0] : sec_handle_in, sec_handle);
		chk("flow_cnt", k + on, fcnt);
		chk("svc_remap", on, svc_remap);
		chk("grant", on ? gr : grant_ref_in, grant_ref);
		chk("keys", on, keys_kept);
		chk("rng_sub", on ? vn[13:0] : init_handle_in, ranging_handle);
		if (on) begin
			chk("flow_old", eo, fo);
			chk("flow_new", en, fn);
			chk("svc_old", vo[13:0], svc_old);
			chk("svc_new", vn[13:0], svc_new);
		end
		$display("substitution test code %0d done", code);
	endtask
	initial begin
		int v;
		rst_b = 1'b0;
		synced_new_chan = 1'b0;
		{primary_handle_in, init_handle_in, sec_handle_in} = '0;
		grant_ref_in = 32'h0;
		desc_rd_addr = '0;
		void'($urandom(32'haad6));
		repeat (2) @(posedge clk);
		chk("rst_level", LVL_FULL, init_level);
		rst_b <= 1'b1;
		for (int c = 0; c < 7; c++) begin
			v = (c == 5) ? $urandom_range(255, 5) : (c == 6) ? 256 : c;
			rnd_in();
			if (v < 256) begin
				pb(8'h03); pb(8'h01); pb(v[7:0]);
			end
			decide();
			chk("level", exp_level(v), init_level);
			chk("rng_handle", v inside {[1:4]} ? primary_handle_in : init_handle_in,
				ranging_handle);
			chk("rng_init", v == 1 || v == 3, ranging_initial_ok);
			chk("rng_sta", v == 2 || v == 3, ranging_station_ok);
			chk("rng_none", v == 4, ranging_none);
		end
		$display("level test done");
		subst(8'h01);
		subst(8'h00);
		subst(8'h02);
		rnd_in();
		pb(8'h03); pb(8'h01); pb(8'h04);
		headend_model_i.put_desc(300);
		decide();
		chk("sec_kept", sec_handle_in, sec_handle);
		chk("grant_kept", grant_ref_in, grant_ref);
		chk("svc_kept", 0, svc_remap);
		chk("chan_kept", 0, up_chan_change);
		chk("desc_len", 300, desc_len);
		chk("desc_wait", 0, desc_apply);
		@(posedge clk) synced_new_chan <= 1'b1;
		repeat (2) @(negedge clk);
		chk("desc_apply", 1, desc_apply);
		foreach (ad[i]) begin
			@(posedge clk) desc_rd_addr <= ad[i][`DESC_AW-1:0];
			repeat (2) @(negedge clk);
			chk("desc_byte", exp_desc(ad[i]), desc_rd_data);
		end
		@(posedge clk) synced_new_chan <= 1'b0;
		$display("descriptor test done");
		complete_run();
	end
endmodule // channel_change_directive_decoder_bench
